// [src/cfg_id_cmd_defs.vh]
`ifndef CFG_ID_CMD_DEFS_VH
`define CFG_ID_CMD_DEFS_VH

// Register offsets (byte addresses, same on both sides)
`define OFS_IDENTITY      8'h00
`define OFS_COMMAND       8'h04
// Address bits used for word select
`define ADDR_HI           7
`define ADDR_LO           2
`define WORD_IDENTITY     6'h00
`define WORD_COMMAND      6'h01

// Identity word fields
`define ID_MAKER_HI       15
`define ID_MAKER_LO       0
`define ID_PART_HI        31
`define ID_PART_LO        16
// Arbitrary neutral defaults, not any real part's codes
`define ID_MAKER_DEFAULT  16'h1234
`define ID_PART_DEFAULT   16'h5678
`define ID_BLANK          16'hFFFF

// Command word fields
`define CMD_IO_EN         0
`define CMD_MEM_EN        1
`define CMD_MASTER_EN     2
`define CMD_MWI_EN        4
`define CMD_PERR_EN       6
`define CMD_SERR_EN       8
// Writable bits: 0,1,2,4,6,8
`define CMD_WR_MASK       16'h0157
`define CMD_RESET         16'h0000

// Status bit for detected parity error
`define STS_PERR_BIT      15

`endif

// [src/cfg_lane_merge.v]
`timescale 1ns/1ns
// Byte-lane merge of write data into an old word under a writable mask
module cfg_lane_merge #(
    parameter WIDTH = 32
) (
    input  wire [WIDTH-1:0]   old_i,
    input  wire [WIDTH-1:0]   wdata_i,
    input  wire [WIDTH/8-1:0] be_i,
    input  wire [WIDTH-1:0]   wmask_i,
    output wire [WIDTH-1:0]   new_o
);
    wire [WIDTH-1:0] lane_m;
    genvar g;
    // Expand byte enables to bit mask
    generate
        for (g = 0; g < WIDTH/8; g = g + 1) begin : lanes
            assign lane_m[g*8 +: 8] = {8{be_i[g]}};
        end
    endgenerate
    // Only enabled, writable bits take new data
    assign new_o = (old_i & ~(lane_m & wmask_i)) | (wdata_i & lane_m & wmask_i);
endmodule

// [src/cfg_sync2.v]
`timescale 1ns/1ns
// Two-flop synchroniser for pin-level inputs
module cfg_sync2 #(
    parameter WIDTH = 1
) (
    input  wire             clk_i,
    input  wire             rstn_i,
    input  wire [WIDTH-1:0] d_i,
    output reg  [WIDTH-1:0] q_o
);
    reg [WIDTH-1:0] meta_r;
    // First stage feeds only the second; reset to the idle high of low-active pins
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_r <= {WIDTH{1'b1}};
            q_o    <= {WIDTH{1'b1}};
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule

// [src/cfg_id_cmd.v]
`timescale 1ns/1ns
`include "cfg_id_cmd_defs.vh"
module cfg_id_cmd (
    input  wire        clk_i,
    input  wire        rstn_i,
    // PCI configuration access
    input  wire        pci_cfg_wr_i,
    input  wire        pci_cfg_rd_i,
    input  wire [7:0]  pci_cfg_addr_i,
    input  wire [31:0] pci_cfg_wdata_i,
    input  wire [3:0]  pci_cfg_be_i,
    output reg  [31:0] pci_cfg_rdata_o,
    output reg         pci_cfg_ack_o,
    // Local processor access
    input  wire        loc_wr_i,
    input  wire        loc_rd_i,
    input  wire [7:0]  loc_addr_i,
    input  wire [31:0] loc_wdata_i,
    input  wire [3:0]  loc_be_i,
    output reg  [31:0] loc_rdata_o,
    output reg         loc_ack_o,
    // Serial EEPROM loader
    input  wire        ee_load_i,
    input  wire [31:0] ee_id_i,
    // Decode and master requests from the data paths
    input  wire        io_hit_i,
    input  wire        mem_hit_i,
    input  wire        master_req_i,
    input  wire        dm_mwi_sel_i,
    input  wire        dma_mwi_sel_i,
    input  wire        fbb_same_target_i,
    // Error events (same clock)
    input  wire        parity_err_i,
    input  wire        sys_err_i,
    input  wire        perr_stat_clr_i,
    // Pins, sampled through synchronisers
    input  wire        perr_n_pin_i,
    input  wire        serr_n_pin_i,
    // Outcomes, status, register copies and pin observations
    output reg         io_claim_o,
    output reg         mem_claim_o,
    output reg         master_req_o,
    output reg         dm_mwi_o,
    output reg         dma_mwi_o,
    output reg         fbb_o,
    output reg         perr_n_o,
    output reg         perr_n_oe_o,
    output reg         serr_n_o,
    output reg         serr_n_oe_o,
    output reg         perr_stat_o,
    output reg  [15:0] cmd_o,
    output reg  [31:0] id_o,
    output reg         perr_pin_seen_o,
    output reg         serr_pin_seen_o
);
    reg  [31:0] id_r;
    reg  [31:0] id_nxt;
    reg  [15:0] cmd_r;
    reg  [15:0] cmd_nxt;
    reg         perr_stat_r;
    wire [31:0] id_loc_new;
    wire [31:0] cmd_pci_new;
    wire [31:0] cmd_loc_new;
    wire [1:0]  pins_s;
    wire        pci_id_sel;
    wire        pci_cmd_sel;
    wire        loc_id_sel;
    wire        loc_cmd_sel;
    wire [15:0] ee_maker;
    wire [15:0] ee_part;

    // Word decode for both sides
    assign pci_id_sel  = (pci_cfg_addr_i[`ADDR_HI:`ADDR_LO] == `WORD_IDENTITY);
    assign pci_cmd_sel = (pci_cfg_addr_i[`ADDR_HI:`ADDR_LO] == `WORD_COMMAND);
    assign loc_id_sel  = (loc_addr_i[`ADDR_HI:`ADDR_LO] == `WORD_IDENTITY);
    assign loc_cmd_sel = (loc_addr_i[`ADDR_HI:`ADDR_LO] == `WORD_COMMAND);

    // Blank EEPROM fields fall back to built-in defaults
    assign ee_maker = (ee_id_i[`ID_MAKER_HI:`ID_MAKER_LO] == `ID_BLANK) ?
                      `ID_MAKER_DEFAULT : ee_id_i[`ID_MAKER_HI:`ID_MAKER_LO];
    assign ee_part  = (ee_id_i[`ID_PART_HI:`ID_PART_LO] == `ID_BLANK) ?
                      `ID_PART_DEFAULT : ee_id_i[`ID_PART_HI:`ID_PART_LO];

    // Lane merges: local identity, command from either side
    cfg_lane_merge #(.WIDTH(32)) u_id_loc (
        .old_i   (id_r),
        .wdata_i (loc_wdata_i),
        .be_i    (loc_be_i),
        .wmask_i (32'hFFFF_FFFF),
        .new_o   (id_loc_new)
    );
    cfg_lane_merge #(.WIDTH(32)) u_cmd_pci (
        .old_i   ({16'h0000, cmd_r}),
        .wdata_i (pci_cfg_wdata_i),
        .be_i    (pci_cfg_be_i),
        .wmask_i ({16'h0000, `CMD_WR_MASK}),
        .new_o   (cmd_pci_new)
    );
    cfg_lane_merge #(.WIDTH(32)) u_cmd_loc (
        .old_i   ({16'h0000, cmd_r}),
        .wdata_i (loc_wdata_i),
        .be_i    (loc_be_i),
        .wmask_i ({16'h0000, `CMD_WR_MASK}),
        .new_o   (cmd_loc_new)
    );

    // Pin observers
    cfg_sync2 #(.WIDTH(2)) u_pins (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .d_i    ({serr_n_pin_i, perr_n_pin_i}),
        .q_o    (pins_s)
    );

    // Identity next value: EEPROM load beats local write; PCI cannot write
    always @* begin
        id_nxt = id_r;
        if (ee_load_i) begin
            id_nxt = {ee_part, ee_maker};
        end else if (loc_wr_i && loc_id_sel) begin
            id_nxt = id_loc_new;
        end
    end

    // Command next value: local write after PCI write wins a collision
    always @* begin
        cmd_nxt = cmd_r;
        if (pci_cfg_wr_i && pci_cmd_sel) begin
            cmd_nxt = cmd_pci_new[15:0];
        end
        if (loc_wr_i && loc_cmd_sel) begin
            cmd_nxt = cmd_loc_new[15:0];
        end
    end

    // Identity and command register state
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            id_r  <= {`ID_PART_DEFAULT, `ID_MAKER_DEFAULT};
            cmd_r <= `CMD_RESET;
        end else begin
            id_r  <= id_nxt;
            cmd_r <= cmd_nxt;
        end
    end

    // Sticky parity status; set wins over clear
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            perr_stat_r <= 1'b0;
        end else begin
            if (parity_err_i) begin
                perr_stat_r <= 1'b1;
            end else if (perr_stat_clr_i) begin
                perr_stat_r <= 1'b0;
            end
        end
    end

    // PCI read and acknowledge port, one cycle after the request
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pci_cfg_rdata_o <= 32'h0000_0000;
            pci_cfg_ack_o   <= 1'b0;
        end else begin
            pci_cfg_ack_o <= pci_cfg_rd_i | pci_cfg_wr_i;
            if (pci_cfg_rd_i) begin
                pci_cfg_rdata_o <= pci_id_sel  ? id_r :
                                   pci_cmd_sel ? {16'h0000, cmd_r} : 32'h0000_0000;
            end
        end
    end

    // Local read and acknowledge port, one cycle after the request
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            loc_rdata_o <= 32'h0000_0000;
            loc_ack_o   <= 1'b0;
        end else begin
            loc_ack_o <= loc_rd_i | loc_wr_i;
            if (loc_rd_i) begin
                loc_rdata_o <= loc_id_sel  ? id_r :
                               loc_cmd_sel ? {16'h0000, cmd_r} : 32'h0000_0000;
            end
        end
    end

    // I/O claim gated by the I/O enable
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            io_claim_o <= 1'b0;
        end else begin
            io_claim_o <= io_hit_i & cmd_r[`CMD_IO_EN];
        end
    end

    // Memory claim gated by the memory enable
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mem_claim_o <= 1'b0;
        end else begin
            mem_claim_o <= mem_hit_i & cmd_r[`CMD_MEM_EN];
        end
    end

    // Master request withheld without the master enable
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            master_req_o <= 1'b0;
        end else begin
            master_req_o <= master_req_i & cmd_r[`CMD_MASTER_EN];
        end
    end

    // Direct-master invalidate writes need the common enable
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dm_mwi_o <= 1'b0;
        end else begin
            dm_mwi_o <= dm_mwi_sel_i & cmd_r[`CMD_MWI_EN];
        end
    end

    // DMA invalidate writes need the common enable
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dma_mwi_o <= 1'b0;
        end else begin
            dma_mwi_o <= dma_mwi_sel_i & cmd_r[`CMD_MWI_EN];
        end
    end

    // Back-to-back only towards the previous target
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fbb_o <= 1'b0;
        end else begin
            fbb_o <= fbb_same_target_i;
        end
    end

    // Parity error pin driver, open-drain style
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            perr_n_o    <= 1'b1;
            perr_n_oe_o <= 1'b0;
        end else begin
            perr_n_oe_o <= parity_err_i & cmd_r[`CMD_PERR_EN];
            perr_n_o    <= ~(parity_err_i & cmd_r[`CMD_PERR_EN]);
        end
    end

    // System error pin driver, open-drain style
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            serr_n_o    <= 1'b1;
            serr_n_oe_o <= 1'b0;
        end else begin
            serr_n_oe_o <= sys_err_i & cmd_r[`CMD_SERR_EN];
            serr_n_o    <= ~(sys_err_i & cmd_r[`CMD_SERR_EN]);
        end
    end

    // Parity status output
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            perr_stat_o <= 1'b0;
        end else begin
            perr_stat_o <= perr_stat_r;
        end
    end

    // Register copies for the data paths
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd_o <= `CMD_RESET;
            id_o  <= {`ID_PART_DEFAULT, `ID_MAKER_DEFAULT};
        end else begin
            cmd_o <= cmd_r;
            id_o  <= id_r;
        end
    end

    // Low level seen on the synchronised error pins
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            perr_pin_seen_o <= 1'b0;
            serr_pin_seen_o <= 1'b0;
        end else begin
            perr_pin_seen_o <= ~pins_s[0];
            serr_pin_seen_o <= ~pins_s[1];
        end
    end
endmodule

// [bench/cfg_id_cmd_checker.sv]
`timescale 1ns/1ns
// Gating, fixed bits, error pins and access timing
module cfg_id_cmd_checker (
    input wire        clk_i,
    input wire        rstn_i,
    input wire        pci_cfg_wr_i,
    input wire        pci_cfg_rd_i,
    input wire        pci_cfg_ack_o,
    input wire        loc_wr_i,
    input wire        ee_load_i,
    input wire        io_hit_i,
    input wire        dm_mwi_sel_i,
    input wire        parity_err_i,
    input wire        sys_err_i,
    input wire        io_claim_o,
    input wire        dm_mwi_o,
    input wire        perr_n_o,
    input wire        perr_n_oe_o,
    input wire        serr_n_oe_o,
    input wire        perr_stat_o,
    input wire [15:0] cmd_o,
    input wire [31:0] id_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    // Parity event, then the enable as the logic saw it (copy lags a cycle)
    sequence s_perr_hit;
        parity_err_i ##1 cmd_o[6];
    endsequence
    // Outcomes follow their cause one cycle late, gated by the enable
    chk_io_gate: assert property (io_claim_o == ($past(io_hit_i) && cmd_o[0]))
        else $error("io claim gating wrong");
    chk_mwi_gate: assert property (dm_mwi_o == ($past(dm_mwi_sel_i) && cmd_o[4]))
        else $error("mwi gating wrong");
    chk_cmd_fixed: assert property ((cmd_o & 16'hFEA8) == 16'h0000)
        else $error("fixed command bit set");
    chk_perr_drive: assert property (s_perr_hit |-> perr_n_oe_o && !perr_n_o)
        else $error("parity pin not driven");
    chk_perr_gate: assert property ($rose(perr_n_oe_o) |-> $past(parity_err_i) && cmd_o[6])
        else $error("parity pin driven unasked");
    chk_perr_stat: assert property (parity_err_i |-> ##2 perr_stat_o)
        else $error("parity status not set");
    chk_serr_gate: assert property ((sys_err_i ##1 !cmd_o[8]) |-> !serr_n_oe_o)
        else $error("system error pin driven");
    chk_ack_time: assert property (pci_cfg_ack_o == $past(pci_cfg_rd_i || pci_cfg_wr_i))
        else $error("ack timing wrong");
    chk_id_source: assert property ($changed(id_o) |-> $past(loc_wr_i || ee_load_i, 2))
        else $error("identity changed unasked");
endmodule
bind cfg_id_cmd cfg_id_cmd_checker i_chk (.*);

// [bench/cfg_host_model.sv]
`timescale 1ns/1ns
// Config-cycle master: one-cycle strobe, data taken with the ack
module cfg_host_model (
    input  wire        clk_i,
    output reg         wr_o = 1'b0,
    output reg         rd_o = 1'b0,
    output reg  [7:0]  addr_o = 8'h00,
    output reg  [31:0] wdata_o = 32'h0000_0000,
    output reg  [3:0]  be_o = 4'h0,
    input  wire [31:0] rdata_i,
    input  wire        ack_i
);
    // Released address, data and byte enables show inverted values, never stale ones; both strobes drop low
    task xfer(input w, input [7:0] a, input [31:0] d, input [3:0] b, output [31:0] q);
        begin
            #1;
            wr_o = w;
            rd_o = !w;
            addr_o = a;
            wdata_o = d;
            be_o = b;
            @(posedge clk_i);
            #1;
            wr_o = 1'b0;
            rd_o = 1'b0;
            addr_o = ~a;
            wdata_o = ~d;
            be_o = ~b;
            @(posedge clk_i);
            q = ack_i ? rdata_i : 32'hxxxx_xxxx;
        end
    endtask
endmodule

// [bench/tb.sv]
`timescale 1ns/1ns
`include "cfg_id_cmd_defs.vh"
module tb;
    localparam [31:0] ID_DEF = {`ID_PART_DEFAULT, `ID_MAKER_DEFAULT};
    reg         clk_i = 0, rstn_i = 0, ee_load_i = 0, io_hit_i = 0, master_req_i = 0;
    reg         dm_mwi_sel_i = 0, parity_err_i = 0, sys_err_i = 0, perr_stat_clr_i = 0;
    reg  [31:0] ee_id_i = 0, q;
    reg         fbb_same_target_i = 0, perr_n_pin_i = 1, serr_n_pin_i = 1;
    wire        pci_cfg_wr_i, pci_cfg_rd_i, pci_cfg_ack_o, loc_wr_i, loc_rd_i, loc_ack_o;
    wire [7:0]  pci_cfg_addr_i, loc_addr_i;
    wire [31:0] pci_cfg_wdata_i, loc_wdata_i, pci_cfg_rdata_o, loc_rdata_o, id_o;
    wire [3:0]  pci_cfg_be_i, loc_be_i;
    wire        io_claim_o, mem_claim_o, master_req_o, dm_mwi_o, dma_mwi_o, fbb_o, perr_n_o;
    wire        perr_n_oe_o, serr_n_o, serr_n_oe_o, perr_stat_o, perr_pin_seen_o, serr_pin_seen_o;
    wire [15:0] cmd_o;
    integer     num_errors = 0, checks_done = 0, cycles = 0;

    cfg_id_cmd i_dut (.mem_hit_i(io_hit_i), .dma_mwi_sel_i(dm_mwi_sel_i), .*);
    cfg_host_model i_pci (.clk_i(clk_i), .wr_o(pci_cfg_wr_i), .rd_o(pci_cfg_rd_i),
        .addr_o(pci_cfg_addr_i), .wdata_o(pci_cfg_wdata_i), .be_o(pci_cfg_be_i),
        .rdata_i(pci_cfg_rdata_o), .ack_i(pci_cfg_ack_o));
    cfg_host_model i_loc (.clk_i(clk_i), .wr_o(loc_wr_i), .rd_o(loc_rd_i), .addr_o(loc_addr_i),
        .wdata_o(loc_wdata_i), .be_o(loc_be_i), .rdata_i(loc_rdata_o), .ack_i(loc_ack_o));

    // Clock and hang guard
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == 2000) begin
            num_errors = num_errors + 1;
            stop_test;
        end
    end
    task stop_test;
        begin
            $display("checks %0d errors %0d", checks_done, num_errors);
            if (num_errors == 0 && checks_done > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] got, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task rd(input [7:0] a);
        i_pci.xfer(1'b0, a, 32'h0000_0000, 4'hF, q);
    endtask
    // Defaults, PCI write ignored, local byte lane, loader with blank half
    task t_id;
        begin
            rd(8'h00);
            chk("id_reset", q, ID_DEF);
            i_pci.xfer(1'b1, 8'h00, 32'hAAAA_AAAA, 4'hF, q);
            rd(8'h00);
            chk("id_pci_wr", q, ID_DEF);
            i_loc.xfer(1'b1, 8'h00, 32'hAAAA_AA55, 4'h1, q);
            rd(8'h00);
            chk("id_loc_byte", q, {ID_DEF[31:8], 8'h55});
            #1 ee_id_i = 32'hFFFF_ABCD;
            ee_load_i = 1;
            @(posedge clk_i);
            #1 ee_load_i = 0;
            rd(8'h00);
            chk("id_ee", q, {ID_DEF[31:16], 16'hABCD});
        end
    endtask
    // Reset value, fixed bits, lane select from the local side
    task t_cmd;
        begin
            rd(8'h04);
            chk("cmd_reset", q[15:0], 32'h0000_0000);
            i_pci.xfer(1'b1, 8'h04, 32'hFFFF_FFFF, 4'hF, q);
            rd(8'h04);
            chk("cmd_ones", q[15:0], 32'h0000_0157);
            i_loc.xfer(1'b1, 8'h04, 32'h0000_0000, 4'h1, q);
            rd(8'h04);
            chk("cmd_lane", q[15:0], 32'h0000_0100);
            i_loc.xfer(1'b0, 8'h04, 32'h0000_0000, 4'hF, q);
            chk("cmd_loc_rd", q[15:0], 32'h0000_0100);
        end
    endtask
    // Decode and master requests held against the enables
    task t_gate(input [15:0] c);
        begin
            i_pci.xfer(1'b1, 8'h04, {16'h0000, c}, 4'h3, q);
            #1 io_hit_i = 1;
            master_req_i = 1;
            dm_mwi_sel_i = 1;
            fbb_same_target_i = 1;
            repeat (2) @(posedge clk_i);
            #1 chk("fbb", fbb_o, 1);
            chk("io", io_claim_o, c[0]);
            chk("mem", mem_claim_o, c[1]);
            chk("mst", master_req_o, c[2]);
            chk("dm_mwi", dm_mwi_o, c[4]);
            chk("dma_mwi", dma_mwi_o, c[4]);
            io_hit_i = 0;
            master_req_i = 0;
            dm_mwi_sel_i = 0;
            fbb_same_target_i = 0;
            @(posedge clk_i);
        end
    endtask
    // Error events with the pin enables off and on
    task t_err(input [15:0] c);
        begin
            i_pci.xfer(1'b1, 8'h04, {16'h0000, c}, 4'h3, q);
            #1 parity_err_i = 1;
            sys_err_i = 1;
            @(posedge clk_i);
            #1 parity_err_i = 0;
            sys_err_i = 0;
            chk("perr_oe", perr_n_oe_o, c[6]);
            chk("perr_out", perr_n_o, !c[6]);
            chk("serr_oe", serr_n_oe_o, c[8]);
            chk("serr_out", serr_n_o, !c[8]);
            @(posedge clk_i);
            #1 chk("perr_stat", perr_stat_o, 1);
            perr_stat_clr_i = 1;
            @(posedge clk_i);
            #1 perr_stat_clr_i = 0;
            @(posedge clk_i);
        end
    endtask
    // Mid-run reset: copies back to defaults, no false pin event; then low pins seen
    task t_pins;
        begin
            #1 rstn_i = 0;
            @(posedge clk_i);
            #1 rstn_i = 1;
            repeat (2) begin
                @(posedge clk_i);
                #1 chk("perr_idle", perr_pin_seen_o, 0);
                chk("serr_idle", serr_pin_seen_o, 0);
            end
            chk("cmd_rst2", cmd_o, 32'h0000_0000);
            chk("id_rst2", id_o, ID_DEF);
            perr_n_pin_i = 0;
            serr_n_pin_i = 0;
            repeat (3) @(posedge clk_i);
            #1 chk("perr_seen", perr_pin_seen_o, 1);
            chk("serr_seen", serr_pin_seen_o, 1);
            perr_n_pin_i = 1;
            serr_n_pin_i = 1;
            repeat (3) @(posedge clk_i);
        end
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        #1 rstn_i = 1;
        t_id;
        t_cmd;
        t_gate(16'h0000);
        t_gate(16'h0017);
        t_gate(16'h0005);
        t_err(16'h0000);
        t_err(16'h0140);
        t_pins;
        stop_test;
    end
endmodule
